// file: inc/sram_train_pkg.sv
// constants and types for the training controller of a two-port synchronous sram
// assumes the controller clock runs at CLK_MHZ and the device samples strobes active low
package sram_train_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned RSS_US      = 200;
  localparam int unsigned RSS_CYC     = RSS_US * CLK_MHZ;
  localparam int unsigned RSH_CYC     = 400000;
  localparam int unsigned PLL_CYC     = 10000;
  localparam int unsigned GUARD_CYC   = 32;
  localparam int unsigned CFG_SETUP   = 8;
  localparam int unsigned LOOP_BEATS  = 64;
  localparam int unsigned MEM_BURST   = 16;

  // ==========================================================================
  // widths and layout
  localparam int          CNT_W       = 20;
  localparam int          ADDR_W      = 25;
  localparam int          LB_W        = 13;
  localparam int          STRAP_W     = 14;
  localparam int          CFG_DATA_W  = 8;
  localparam int          CFG_REG_LSB = 8;
  localparam logic [2:0]  REG_IMP     = 3'h1;
  localparam logic [2:0]  REG_OPT     = 3'h2;
  localparam int          OPT_WT_BIT  = 7;
  localparam int          OPT_DINV    = 6;
  localparam int          OPT_ADDR_INVERT_FLAG    = 5;
  localparam int          OPT_PAR     = 4;
  localparam int          LB_GROUPS   = 3;
  // {select1_n, select0_n} for each loopback group
  localparam logic [1:0]  LB_SEL_G0   = 2'h0;
  localparam logic [1:0]  LB_SEL_G1   = 2'h2;
  localparam logic [1:0]  LB_SEL_G2   = 2'h1;

  // ==========================================================================
  // sequencer
  typedef enum logic [8:0] {
    ST_DEVRST = 9'h001, ST_HOLD = 9'h002, ST_IDLE = 9'h004, ST_CFG  = 9'h008, ST_GAP = 9'h010,
    ST_PLL    = 9'h020, ST_LOOP = 9'h040, ST_MEM  = 9'h080, ST_SPARE = 9'h100
  } state_t;

  typedef enum logic [4:0] {
    PH_IMP = 5'h01, PH_TRAIN = 5'h02, PH_LOOP = 5'h04, PH_MEM = 5'h08, PH_RUN = 5'h10
  } phase_t;

endpackage : sram_train_pkg

// file: hw/sram_train_ctrl.sv
// training and initialisation sequencer that drives a two-port sram through its pins
// assumes port_a_out_clk_i is the device output clock, unrelated to mclk_i
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// link side capture of loopback words, handed over by req/ack toggles
module lb_capture #(
  parameter int LB_W = 13
) (
  input  wire logic            link_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            ack_i,
  input  wire logic [LB_W-1:0] dq_i,
  output logic                 req_o,
  output logic [LB_W-1:0]      word_o
);
  typedef struct packed {
    logic            ack_s1;
    logic            ack_s2;
    logic            req;
    logic [LB_W-1:0] word;
  } cap_t;

  cap_t cur;
  cap_t next_cur;

  always_comb
  begin
    next_cur        = cur;
    next_cur.ack_s1 = ack_i;
    next_cur.ack_s2 = cur.ack_s1;
    // only the rising-edge beat is kept; it carries the unmodified sample
    if (cur.req == cur.ack_s2)
    begin
      next_cur.word = dq_i;
      next_cur.req  = ~cur.req;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign req_o  = cur.req;
  assign word_o = cur.word;
endmodule : lb_capture

// Function
// - never request two modes at once
// - 32 quiet clocks around configuration mode
// - configuration uses only port A load
// - 32 quiet clocks around loopback mode
// - wait 32 clocks before toggling loopback
// - load strobes toggle as loopback stimulus
// - memory access only with selects deasserted
// - no access 32 clocks before leaving
// - configure impedance, then training options
// - wait PLL lock after impedance
// - deskew order, then runtime options
// - retrain restarts at training options
module sram_train_ctrl
  import sram_train_pkg::*;
#(
  parameter int unsigned DQ_W      = 18,
  parameter int unsigned RSS_CNT   = sram_train_pkg::RSS_CYC,
  parameter int unsigned RSH_CNT   = sram_train_pkg::RSH_CYC,
  parameter int unsigned PLL_CNT   = sram_train_pkg::PLL_CYC,
  parameter logic [17:0] DQ_PATTERN = 18'h2aa55
) (
  input  wire logic                         mclk_i,
  input  wire logic                         arst_n_i,
  input  wire logic                         start_i,
  input  wire logic                         retrain_i,
  input  wire logic [7:0]                   imp_value_i,
  input  wire logic                         addr_inv_en_i,
  input  wire logic                         data_inv_en_i,
  input  wire logic [sram_train_pkg::STRAP_W-1:0] strap_i,
  input  wire logic                         port_a_out_clk_i,
  input  wire logic [DQ_W-1:0]              port_a_dq_i,
  output logic [DQ_W-1:0]                   port_a_dq_o,
  output logic                              port_a_dq_oe_o,
  output logic                              dev_rst_n_o,
  output logic                              cfg_n_o,
  output logic                              loop_select0_n_o,
  output logic                              loop_select1_n_o,
  output logic                              port_a_load_n_o,
  output logic                              port_b_load_n_o,
  output logic                              port_a_rw_n_o,
  output logic                              port_b_rw_n_o,
  output logic [sram_train_pkg::ADDR_W-1:0] addr_o,
  output logic                              addr_invert_flag_o,
  output logic                              addr_parity_bit_o,
  output logic                              ready_o,
  output logic                              busy_o,
  output logic                              trained_o,
  output logic [sram_train_pkg::LB_W-1:0]   lb_word_o,
  output logic                              lb_valid_o
);
  import sram_train_pkg::*;

  typedef struct packed {
    state_t            st;
    phase_t            ph;
    logic [CNT_W-1:0]  cnt;
    logic [1:0]        grp;
    logic              pass;
    logic              dev_rst_n;
    logic              cfg_n;
    logic              sel0_n;
    logic              sel1_n;
    logic              lda_n;
    logic              ldb_n;
    logic              rwa_n;
    logic              rwb_n;
    logic [ADDR_W-1:0] addr;
    logic              ap;
    logic              addr_invert_flag;
    logic [DQ_W-1:0]   dq;
    logic              dq_oe;
    logic              ready;
    logic              busy;
    logic              trained;
    logic [LB_W-1:0]   lb_word;
    logic              lb_valid;
    logic              req_s1;
    logic              req_s2;
    logic              ack;
  } ctl_t;

  // ==========================================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ctl_t            cur;
  ctl_t            next_cur;
  logic            link_req;
  logic [LB_W-1:0] link_word;

  lb_capture #(.LB_W(LB_W)) u_capture (
    .link_clk_i (port_a_out_clk_i),
    .rst_n_i    (rst_n),
    .ack_i      (cur.ack),
    .dq_i       (port_a_dq_i[LB_W-1:0]),
    .req_o      (link_req),
    .word_o     (link_word)
  );

  // ==========================================================================
  // sequencer
  always_comb
  begin
    next_cur          = cur;
    next_cur.cnt      = cur.cnt + CNT_W'(1);
    next_cur.lda_n    = 1'b1;
    next_cur.ldb_n    = 1'b1;
    next_cur.rwa_n    = 1'b1;
    next_cur.rwb_n    = 1'b1;
    next_cur.dq_oe    = 1'b0;
    next_cur.lb_valid = 1'b0;
    next_cur.req_s1   = link_req;
    next_cur.req_s2   = cur.req_s1;
    if (cur.req_s2 != cur.ack)
    begin
      next_cur.lb_word  = link_word;
      next_cur.lb_valid = 1'b1;
      next_cur.ack      = cur.req_s2;
    end
    case (cur.st)
      ST_DEVRST:
      begin
        // straps must stand on the address pins across the reset release
        next_cur.addr = ADDR_W'(strap_i);
        if (cur.cnt == CNT_W'(RSS_CNT - 1))
        begin
          next_cur.st        = ST_HOLD;
          next_cur.cnt       = '0;
          next_cur.dev_rst_n = 1'b1;
        end
      end
      ST_HOLD:
        if (cur.cnt == CNT_W'(RSH_CNT - 1))
        begin
          next_cur.st    = ST_IDLE;
          next_cur.ready = 1'b1;
          next_cur.addr  = '0;
        end
      ST_IDLE:
      begin
        next_cur.cnt = '0;
        if (start_i)
        begin
          next_cur.st      = ST_CFG;
          next_cur.ph      = PH_IMP;
          next_cur.busy    = 1'b1;
          next_cur.trained = 1'b0;
          next_cur.cfg_n   = 1'b0;
        end
        else if (retrain_i && cur.trained)
        begin
          next_cur.st    = ST_CFG;
          next_cur.ph    = PH_TRAIN;
          next_cur.busy  = 1'b1;
          next_cur.cfg_n = 1'b0;
        end
      end
      ST_CFG:
      begin
        // port B load and both selects stay high here
        if (cur.cnt == CNT_W'(CFG_SETUP))
        begin
          next_cur.lda_n = 1'b0;
          next_cur.rwa_n = 1'b0;
          next_cur.addr  = '0;
          if (cur.ph == PH_IMP)
          begin
            next_cur.addr[CFG_REG_LSB +: 3]      = REG_IMP;
            next_cur.addr[CFG_DATA_W-1:0]        = imp_value_i;
          end
          else
          begin
            next_cur.addr[CFG_REG_LSB +: 3] = REG_OPT;
            next_cur.addr[OPT_WT_BIT]       = (cur.ph == PH_TRAIN);
            next_cur.addr[OPT_PAR]          = (cur.ph != PH_TRAIN);
            next_cur.addr[OPT_DINV]         = data_inv_en_i;
            next_cur.addr[OPT_ADDR_INVERT_FLAG]         = addr_inv_en_i;
          end
        end
        else if (cur.cnt == CNT_W'(CFG_SETUP + 1))
        begin
          next_cur.cfg_n = 1'b1;
          next_cur.addr  = '0;
          next_cur.st    = ST_GAP;
          next_cur.cnt   = '0;
        end
      end
      ST_GAP:
        // quiet interval between modes
        if (cur.cnt == CNT_W'(GUARD_CYC - 1))
        begin
          next_cur.cnt = '0;
          case (cur.ph)
            PH_IMP:   next_cur.st = ST_PLL;
            PH_TRAIN:
            begin
              next_cur.st     = ST_LOOP;
              next_cur.grp    = '0;
              {next_cur.sel1_n, next_cur.sel0_n} = LB_SEL_G0;
            end
            PH_LOOP:
            begin
              next_cur.st   = ST_MEM;
              next_cur.pass = 1'b0;
            end
            PH_MEM:
            begin
              next_cur.st    = ST_CFG;
              next_cur.ph    = PH_RUN;
              next_cur.cfg_n = 1'b0;
            end
            default:
            begin
              next_cur.st      = ST_IDLE;
              next_cur.busy    = 1'b0;
              next_cur.trained = 1'b1;
            end
          endcase
        end
      ST_PLL:
        if (cur.cnt == CNT_W'(PLL_CNT - 1))
        begin
          next_cur.st    = ST_CFG;
          next_cur.ph    = PH_TRAIN;
          next_cur.cnt   = '0;
          next_cur.cfg_n = 1'b0;
        end
      ST_LOOP:
      begin
        // inputs held still while the device settles in loopback
        if (cur.cnt >= CNT_W'(GUARD_CYC))
        begin
          next_cur.addr  = ~cur.addr;
          next_cur.lda_n = cur.cnt[0];
          next_cur.ldb_n = ~cur.cnt[0];
          next_cur.rwa_n = cur.cnt[0];
          next_cur.rwb_n = ~cur.cnt[0];
        end
        if (cur.cnt == CNT_W'(GUARD_CYC + LOOP_BEATS - 1))
        begin
          next_cur.cnt  = '0;
          next_cur.addr = '0;
          // a load left low here would read as an access once the selects drop
          next_cur.lda_n = 1'b1;
          next_cur.ldb_n = 1'b1;
          next_cur.rwa_n = 1'b1;
          next_cur.rwb_n = 1'b1;
          next_cur.grp  = cur.grp + 2'h1;
          case (cur.grp)
            2'h0:    {next_cur.sel1_n, next_cur.sel0_n} = LB_SEL_G1;
            2'h1:    {next_cur.sel1_n, next_cur.sel0_n} = LB_SEL_G2;
            default:
            begin
              {next_cur.sel1_n, next_cur.sel0_n} = 2'h3;
              next_cur.st = ST_GAP;
              next_cur.ph = PH_LOOP;
            end
          endcase
        end
      end
      ST_MEM:
      begin
        // each pass writes then reads; first pass uses the pattern, second its complement
        next_cur.lda_n = 1'b0;
        // reads revisit the locations the write half of the pass filled
        next_cur.addr  = ADDR_W'(cur.cnt & CNT_W'(MEM_BURST - 1));
        if (cur.cnt < CNT_W'(MEM_BURST))
        begin
          next_cur.rwa_n = 1'b0;
          next_cur.dq_oe = 1'b1;
          next_cur.dq    = cur.pass ? ~DQ_PATTERN[DQ_W-1:0] : DQ_PATTERN[DQ_W-1:0];
        end
        if (cur.cnt == CNT_W'(2 * MEM_BURST - 1))
        begin
          next_cur.cnt  = '0;
          next_cur.pass = 1'b1;
          if (cur.pass)
          begin
            next_cur.lda_n = 1'b1;
            next_cur.rwa_n = 1'b1;
            next_cur.dq_oe = 1'b0;
            next_cur.addr  = '0;
            next_cur.st    = ST_GAP;
            next_cur.ph    = PH_MEM;
          end
        end
      end
      default:
      begin
        next_cur.st  = ST_IDLE;
        next_cur.cnt = '0;
      end
    endcase
    // even parity over the address bus
    next_cur.ap = ^next_cur.addr;
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur        <= '0;
      cur.st     <= ST_DEVRST;
      cur.ph     <= PH_IMP;
      cur.cfg_n  <= 1'b1;
      cur.sel0_n <= 1'b1;
      cur.sel1_n <= 1'b1;
      cur.lda_n  <= 1'b1;
      cur.ldb_n  <= 1'b1;
      cur.rwa_n  <= 1'b1;
      cur.rwb_n  <= 1'b1;
    end
    else
      cur <= next_cur;
  end

  assign port_a_dq_o        = cur.dq;
  assign port_a_dq_oe_o     = cur.dq_oe;
  assign dev_rst_n_o        = cur.dev_rst_n;
  assign cfg_n_o            = cur.cfg_n;
  assign loop_select0_n_o   = cur.sel0_n;
  assign loop_select1_n_o   = cur.sel1_n;
  assign port_a_load_n_o    = cur.lda_n;
  assign port_b_load_n_o    = cur.ldb_n;
  assign port_a_rw_n_o      = cur.rwa_n;
  assign port_b_rw_n_o      = cur.rwb_n;
  assign addr_o             = cur.addr;
  assign addr_invert_flag_o = cur.addr_invert_flag;
  assign addr_parity_bit_o  = cur.ap;
  assign ready_o            = cur.ready;
  assign busy_o             = cur.busy;
  assign trained_o          = cur.trained;
  assign lb_word_o          = cur.lb_word;
  assign lb_valid_o         = cur.lb_valid;

  // ==========================================================================
  // checks
  logic       loop_on;
  logic       mem_act;
  logic [6:0] since_mem;
  logic [6:0] since_cfg;
  logic [6:0] since_loop;

  localparam logic [6:0] GAP_MIN = 7'(GUARD_CYC);

  assign loop_on = !cur.sel0_n || !cur.sel1_n;
  assign mem_act = cur.cfg_n && !loop_on && (!cur.lda_n || !cur.ldb_n);

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      since_mem  <= 7'h7f;
      since_cfg  <= 7'h7f;
      since_loop <= 7'h7f;
    end
    else
    begin
      since_mem  <= mem_act ? 7'h00 : (since_mem == 7'h7f ? since_mem : since_mem + 7'h01);
      since_cfg  <= !cur.cfg_n ? 7'h00 : (since_cfg == 7'h7f ? since_cfg : since_cfg + 7'h01);
      since_loop <= loop_on ? 7'h00 : (since_loop == 7'h7f ? since_loop : since_loop + 7'h01);
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  sequence s_cfg_settle;
    (!cur.cfg_n && cur.lda_n) [*8];
  endsequence

  chk_mode_exclusive: assert property (!(!cur.cfg_n && loop_on))
    else $error("configuration and loopback requested together");
  chk_cfg_quiet_pins: assert property (!cur.cfg_n |-> cur.ldb_n && !loop_on)
    else $error("port B load or loop select asserted in configuration");
  chk_cfg_entry_gap: assert property ($fell(cur.cfg_n) |-> since_mem >= GAP_MIN && since_loop >= GAP_MIN)
    else $error("configuration entered without quiet interval");
  chk_loop_entry_gap: assert property ($rose(loop_on) |-> since_mem >= GAP_MIN && since_cfg >= GAP_MIN)
    else $error("loopback entered without quiet interval");
  chk_mem_access_gap: assert property (mem_act |-> since_cfg >= GAP_MIN && since_loop >= GAP_MIN)
    else $error("memory access too close to another mode");
  chk_leave_mem_gap: assert property ($fell(cur.cfg_n) && since_mem != 7'h7f |-> since_mem >= GAP_MIN)
    else $error("memory access too close to leaving memory mode");
  chk_loop_settle: assert property ($rose(loop_on) |-> $stable(cur.addr) [*8] ##1 ($stable(cur.addr) && cur.lda_n) [*8])
    else $error("loopback inputs toggled before settling");
  chk_cfg_write_setup: assert property ($fell(cur.cfg_n) |-> s_cfg_settle ##1 (!cur.cfg_n && cur.lda_n)
                                        ##1 (!cur.lda_n && !cur.cfg_n) ##1 cur.cfg_n)
    else $error("configuration write not issued after setup");
  chk_pll_wait_end: assert property ($fell(cur.st == ST_PLL) |-> cur.st == ST_CFG && cur.ph == PH_TRAIN)
    else $error("training options not configured after pll wait");
  chk_deskew_order: assert property ($rose(cur.st == ST_MEM) |-> $past(cur.ph) == PH_LOOP)
    else $error("data deskew started before address deskew");
  chk_retrain_entry: assert property (cur.st == ST_IDLE && !start_i && retrain_i && cur.trained
                                      |=> cur.st == ST_CFG && cur.ph == PH_TRAIN)
    else $error("retrain did not restart at training options");

endmodule : sram_train_ctrl

`default_nettype wire

// file: tb/sram_dev_model.sv
// behavioural two-port sram: mode decode, guard checks, config writes, loopback, write training
// assumes mclk_i is its input clock; the bench reads the logs below by hierarchical name
`timescale 1ns/1ps
`default_nettype none
module sram_dev_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cfg_n_i,
  input  wire logic        loop_select0_n_i,
  input  wire logic        loop_select1_n_i,
  input  wire logic        port_a_load_n_i,
  input  wire logic        port_b_load_n_i,
  input  wire logic        port_a_rw_n_i,
  input  wire logic        port_b_rw_n_i,
  input  wire logic [24:0] addr_i,
  input  wire logic        addr_invert_flag_i,
  input  wire logic        addr_parity_bit_i,
  input  wire logic [17:0] port_a_dq_i,
  output logic             port_a_out_clk_o,
  output logic [17:0]      port_a_dq_o
);
  int          cyc = 0;
  int          last_cfg = -1000;
  int          last_lb = -1000;
  int          last_mem = -1000;
  int          lb_entry = 0;
  int          viol = 0;
  int          wr_count = 0;
  int          cfg_cyc [$];
  logic [15:0] cfg_log [$];
  logic [13:0] strap;
  logic        wt = 1'b0;
  logic [35:0] mem [0:31];
  logic [12:0] rise_q [0:16];
  logic [12:0] fall_q [0:16];
  logic        lb_prev = 1'b0;
  logic [28:0] pins_prev = '0;
  logic [28:0] pins;
  logic        rd_on = 1'b0;
  logic [17:0] rd_data = '0;
  logic        ph = 1'b0;
  logic        cfg_act;
  logic        lb_act;
  logic        mem_act;

  assign pins    = {addr_i, port_a_load_n_i, port_b_load_n_i, port_a_rw_n_i, port_b_rw_n_i};
  assign cfg_act = !cfg_n_i;
  assign lb_act  = !loop_select0_n_i || !loop_select1_n_i;
  // loads in loopback are stimulus, never accesses
  assign mem_act = !cfg_act && !lb_act && (!port_a_load_n_i || !port_b_load_n_i);

  function automatic logic [12:0] lb_map(input logic ck);
    case ({loop_select1_n_i, loop_select0_n_i})
      2'h0:    return addr_i[12:0];
      2'h2:    return {addr_invert_flag_i, addr_i[24:13]};
      default: return {addr_parity_bit_i, port_b_rw_n_i, port_b_load_n_i, !ck, ck, !ck, ck,
                       port_a_rw_n_i, port_a_load_n_i, !ck, ck, !ck, ck};
    endcase
  endfunction : lb_map

  // =========================================================================
  // reset straps; reset pin has no termination at all
  always @(posedge rst_n_i)
  begin
    strap = addr_i[13:0];
    wt = 1'b0;
  end

  // =========================================================================
  // mode tracking and guard checks
  always @(posedge mclk_i)
  begin
    cyc++;
    if (rst_n_i)
    begin
      if (cfg_act && (lb_act || !port_b_load_n_i)) viol++;
      if (cfg_act && (cyc - last_lb <= 32 || cyc - last_mem <= 32)) viol++;
      if (lb_act && (cyc - last_cfg <= 32 || cyc - last_mem <= 32)) viol++;
      if (mem_act && (cyc - last_cfg <= 32 || cyc - last_lb <= 32)) viol++;
      if (lb_act && !lb_prev) lb_entry = cyc;
      if (lb_act && cyc != lb_entry && cyc - lb_entry < 32 && pins != pins_prev) viol++;
      if (mem_act && (addr_invert_flag_i || ^{addr_i, addr_parity_bit_i})) viol++;
      if (cfg_act && !port_a_load_n_i && !port_a_rw_n_i)
      begin
        cfg_log.push_back({5'h00, addr_i[10:0]});
        cfg_cyc.push_back(cyc);
        if (addr_i[10:8] == 3'h2) wt = addr_i[7];
      end
      if (mem_act && !port_a_load_n_i && !port_a_rw_n_i)
      begin
        wr_count++;
        mem[addr_i[4:0]] = {port_a_dq_i, wt ? ~port_a_dq_i : port_a_dq_i};
      end
      rd_on = mem_act && port_a_rw_n_i;
      rd_data = mem[addr_i[4:0]][35:18];
      if (cfg_act && !port_a_load_n_i && port_a_rw_n_i)
      begin
        rd_on = 1'b1;
        rd_data = {10'h000, cfg_log[$][7:0]};
      end
      if (cfg_act) last_cfg = cyc;
      if (lb_act) last_lb = cyc;
      if (mem_act) last_mem = cyc;
    end
    lb_prev = lb_act;
    pins_prev = pins;
  end

  // =========================================================================
  // loopback capture on both input clock edges, sixteen clocks deep
  always @(posedge mclk_i)
  begin
    for (int i = 16; i > 0; i--) rise_q[i] <= rise_q[i-1];
    rise_q[0] <= lb_map(1'b1);
  end

  always @(negedge mclk_i)
  begin
    for (int i = 16; i > 0; i--) fall_q[i] <= fall_q[i-1];
    fall_q[0] <= lb_map(1'b0);
  end

  // data leads the output clock by a quarter period so the far side sees it settled
  initial
  begin
    port_a_dq_o = 18'h00000;
    #13;
    forever #40 ph = !ph;
  end
  assign #20 port_a_out_clk_o = ph;

  // rising beat of looped data passes as is, falling beat and upper bits inverted; idle bus toggles so stale values never pass
  always @(ph)
    if (lb_act)
      port_a_dq_o <= {~port_a_dq_o[17:13], ph ? rise_q[16] : ~fall_q[16]};
    else if (rd_on)
      port_a_dq_o <= rd_data;
    else
      port_a_dq_o <= ~port_a_dq_o;
endmodule : sram_dev_model
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the sram training controller facing a behavioural device
// assumes the device shares mclk as input clock and makes its own unrelated output clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t: got %0h want %0h", $time, (a), (b)); end end

module tb_top;
  import sram_train_pkg::*;
  localparam int unsigned PLL = 20;
  logic              mclk = 1'b0;
  logic              arst_n = 1'b0;
  logic              start = 1'b0;
  logic              retrain = 1'b0;
  logic [7:0]        imp = 8'h00;
  logic              addr_invert_flag_en = 1'b0;
  logic              dinv_en = 1'b0;
  logic [13:0]       strap = 14'h2c35;
  logic              out_clk;
  logic [17:0]       ctrl_dq, dev_dq, dq_wire;
  logic              dq_oe, dev_rst_n, cfg_n, sel0_n, sel1_n, lda_n, ldb_n, rwa_n, rwb_n;
  logic [ADDR_W-1:0] addr;
  logic              addr_invert_flag, apar, ready, busy, trained, lb_valid;
  logic [LB_W-1:0]   lb_word;
  logic              seen [0:8191];
  int                err_total = 0;
  int                check_count = 0;
  int                lb_cnt = 0;
  int                lb_run = 0;

  always #5 mclk = !mclk;
  assign dq_wire = dq_oe ? ctrl_dq : dev_dq;

  sram_train_ctrl #(.DQ_W(18), .RSS_CNT(20), .RSH_CNT(40), .PLL_CNT(PLL)) sram_train_ctrl_i (
    .mclk_i(mclk), .arst_n_i(arst_n), .start_i(start), .retrain_i(retrain), .imp_value_i(imp),
    .addr_inv_en_i(addr_invert_flag_en), .data_inv_en_i(dinv_en), .strap_i(strap), .port_a_out_clk_i(out_clk),
    .port_a_dq_i(dq_wire), .port_a_dq_o(ctrl_dq), .port_a_dq_oe_o(dq_oe), .dev_rst_n_o(dev_rst_n),
    .cfg_n_o(cfg_n), .loop_select0_n_o(sel0_n), .loop_select1_n_o(sel1_n), .port_a_load_n_o(lda_n),
    .port_b_load_n_o(ldb_n), .port_a_rw_n_o(rwa_n), .port_b_rw_n_o(rwb_n), .addr_o(addr),
    .addr_invert_flag_o(addr_invert_flag), .addr_parity_bit_o(apar), .ready_o(ready), .busy_o(busy),
    .trained_o(trained), .lb_word_o(lb_word), .lb_valid_o(lb_valid));

  sram_dev_model sram_dev_model_i (
    .mclk_i(mclk), .rst_n_i(dev_rst_n), .cfg_n_i(cfg_n), .loop_select0_n_i(sel0_n),
    .loop_select1_n_i(sel1_n), .port_a_load_n_i(lda_n), .port_b_load_n_i(ldb_n),
    .port_a_rw_n_i(rwa_n), .port_b_rw_n_i(rwb_n), .addr_i(addr), .addr_invert_flag_i(addr_invert_flag),
    .addr_parity_bit_i(apar), .port_a_dq_i(dq_wire), .port_a_out_clk_o(out_clk), .port_a_dq_o(dev_dq));

  // =========================================================================
  // loopback words must be pin samples; only judged well inside loopback
  always @(posedge mclk)
  begin
    #2;
    seen[sram_dev_model_i.rise_q[0]] = 1'b1;
    lb_run = sram_dev_model_i.lb_act ? lb_run + 1 : 0;
    if (lb_valid === 1'b1 && lb_run > 24)
    begin
      lb_cnt++;
      `CHK(seen[lb_word], 1'b1)
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic run_seq(input logic by_retrain);
    int n;
    sram_dev_model_i.cfg_log.delete();
    sram_dev_model_i.cfg_cyc.delete();
    sram_dev_model_i.viol = 0;
    sram_dev_model_i.wr_count = 0;
    lb_cnt = 0;
    foreach (seen[i]) seen[i] = 1'b0;
    @(posedge mclk);
    #1;
    start = !by_retrain;
    retrain = by_retrain;
    @(posedge mclk);
    #1;
    start = 1'b0;
    retrain = 1'b0;
    @(posedge mclk);
    #1;
    n = 0;
    while ((busy !== 1'b0 || trained !== 1'b1) && n < 5000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(n < 5000, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(sram_dev_model_i.viol, 0)
  endtask : run_seq

  task automatic test_reset;
    int n;
    repeat (2) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    `CHK(dev_rst_n, 1'b0)
    `CHK({cfg_n, sel0_n, sel1_n, lda_n, ldb_n}, 5'h1f)
    `CHK(addr[13:0], strap)
    n = 0;
    while (ready !== 1'b1 && n < 300)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(ready, 1'b1)
    `CHK(sram_dev_model_i.strap, strap)
    $display("test reset done");
  endtask : test_reset

  task automatic test_full_train;
    imp = 8'ha6;
    addr_invert_flag_en = 1'b1;
    dinv_en = 1'b0;
    run_seq(1'b0);
    `CHK(sram_dev_model_i.cfg_log.size(), 3)
    `CHK(sram_dev_model_i.cfg_log[0][10:0], {3'h1, imp})
    `CHK(sram_dev_model_i.cfg_log[1][10:4], {3'h2, 1'b1, dinv_en, addr_invert_flag_en, 1'b0})
    `CHK({sram_dev_model_i.cfg_log[2][10:7], sram_dev_model_i.cfg_log[2][4]}, 5'h09)
    `CHK(sram_dev_model_i.cfg_cyc[1] - sram_dev_model_i.cfg_cyc[0] > PLL, 1'b1)
    `CHK(sram_dev_model_i.wr_count, 2 * MEM_BURST)
    `CHK(sram_dev_model_i.mem[0][17:0], ~sram_dev_model_i.mem[0][35:18])
    `CHK(lb_cnt > 0, 1'b1)
    $display("test full training done");
  endtask : test_full_train

  task automatic test_retrain;
    addr_invert_flag_en = 1'b0;
    dinv_en = 1'b1;
    run_seq(1'b1);
    `CHK(sram_dev_model_i.cfg_log.size(), 2)
    `CHK(sram_dev_model_i.cfg_log[0][10:4], {3'h2, 1'b1, 1'b1, 1'b0, 1'b0})
    `CHK(lb_cnt > 0, 1'b1)
    $display("test retrain done");
  endtask : test_retrain

  initial
  begin
    test_reset();
    test_full_train();
    test_retrain();
    report_and_stop();
  end

  // whole run needs about 1150 clocks
  initial
  begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
